// >>> logic/pin_sync.sv
`timescale 1ns/1ns

// Two-stage synchroniser, one chain per bit
module pin_sync #(
  parameter int          WIDTH     = 5,
  parameter logic [4:0]  RESET_VAL = 5'h00
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta[g]   <= RESET_VAL[g];
          sync_o[g] <= RESET_VAL[g];
        end else begin
          meta[g]   <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule

// >>> logic/serial_host_port.sv
`timescale 1ns/1ns
`include "serial_port_params.svh"

// Operation
// [RL1] Strap low selects two-wire mode, otherwise four-wire slave mode.
// [RL2] Four-wire mode is slave only; each transaction is one 16-bit cycle.
// [RL3] Cycle carries 7-bit address, read/write flag, then 8-bit data.
// [RL4] Flag high means register write, flag low means register read.
// [RL5] Serial output is released except while shifting out read data.
// [RL6] Address and data fields travel most significant bit first.
// [RL7] Host keeps select low through a cycle, high between cycles.
// [RL8] Select high resets receive logic and clears the bit counter.
// [RL9] Inputs sampled on clock rise, outputs launched on clock fall.
// [RL10] Four-wire port steps through successive addresses on continued transfers.
// [RL11] Two-wire mode uses clock pin and open-drain data pin.
// [RL12] Data line changes only while clock is low.
// [RL13] Data falling while clock high is a START.
// [RL14] Data rising while clock high is a STOP.
// [RL15] Only the master creates START and STOP; device never does.
// [RL16] Bus busy from START until the next STOP.
// [RL17] Repeated START acts like a first START and restarts addressing.
// [RL18] Chip address 20h with address pin low, 21h high; eighth bit direction.
// [RL19] Write: byte after chip address is register, next byte is data.
// [RL20] Bytes are eight bits MSB first; receiver acknowledges on ninth clock.
// [RL21] Master reads by writing register address, repeated START, then reading.
// [RL22] Register pointer advances by one after each data byte; a two-wire read byte the master refuses leaves it unchanged.
module serial_host_port (
  input  wire logic                      clock_i,
  input  wire logic                      resetn_i,
  input  wire logic                      interface_select_pin_i,
  input  wire logic                      slave_select_n_i,
  input  wire logic                      serial_clock_i,
  input  wire logic                      serial_in_addr_bit_pin_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  output logic                           serial_out_o,
  output logic                           serial_out_oe_o,
  output logic                           bus_busy_o,
  output serial_port_pkg::reg_req_t      reg_req_o,
  input  wire logic [7:0]                reg_rdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [4:0] pins_sync;
  logic       sck_prev;
  logic       sda_prev;

  pin_sync #(
    .WIDTH     (5),
    .RESET_VAL (`SHP_PIN_IDLE)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({interface_select_pin_i, slave_select_n_i, serial_clock_i,
                serial_in_addr_bit_pin_i, sda_i}),
    .sync_o   (pins_sync)
  );

  logic s_interface_select_pin;
  logic s_ss_n;
  logic s_sck;
  logic s_si;
  logic s_sda;
  logic sck_rise;
  logic sck_fall;
  logic spi_mode;
  logic i2c_mode;

  // Named views of the synchronised pins
  assign s_interface_select_pin  = pins_sync[4];
  assign s_ss_n   = pins_sync[3];
  assign s_sck    = pins_sync[2];
  assign s_si     = pins_sync[1];
  assign s_sda    = pins_sync[0];
  assign sck_rise = s_sck & ~sck_prev;
  assign sck_fall = ~s_sck & sck_prev;
  assign i2c_mode = (s_interface_select_pin == `SHP_INTERFACE_SELECT_PIN_I2C_LEVEL); // [RL1]
  assign spi_mode = ~i2c_mode;                        // [RL1]

  // Previous levels start idle-high so release of reset is no edge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      sck_prev <= s_sck;
      sda_prev <= s_sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four-wire slave

  logic [4:0] spi_cnt;
  logic [6:0] spi_shift;
  logic [7:0] spi_addr;
  logic       spi_write;
  logic [7:0] out_shift;

  logic       spi_active;
  logic       spi_hdr_done;
  logic       spi_byte_done;
  logic       spi_launch;
  logic       spi_wr_evt;
  logic       spi_rd_evt;
  logic [7:0] spi_rd_addr;

  // Cycle decode: header after eight rises, data byte after sixteen
  assign spi_active    = spi_mode & ~s_ss_n;                                   // [RL2]
  assign spi_hdr_done  = spi_active & sck_rise & (spi_cnt == `SHP_SPI_HDR_LAST); // [RL3]
  assign spi_byte_done = spi_active & sck_rise & (spi_cnt == `SHP_SPI_BYTE_LAST);
  assign spi_launch    = spi_active & sck_fall & ~spi_write & (spi_cnt >= `SHP_SPI_DATA_FIRST); // [RL5] [RL9]
  assign spi_wr_evt    = spi_byte_done & spi_write;                              // [RL4]
  assign spi_rd_evt    = (spi_hdr_done & ~s_si) | (spi_byte_done & ~spi_write);  // [RL4]
  assign spi_rd_addr   = spi_hdr_done ? {1'b0, spi_shift} : 8'(spi_addr + 8'h01); // [RL10]

  // Holding select high keeps the bit counter and output enable cleared and the write flag set, so a torn cycle is dropped
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spi_cnt         <= 5'h00;
      spi_shift       <= 7'h00;
      spi_addr        <= `SHP_ADDR_RESET;
      spi_write       <= 1'b1;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (!spi_active) begin
      spi_cnt         <= 5'h00;                    // [RL8] [RL7]
      spi_write       <= 1'b1;
      serial_out_oe_o <= 1'b0;                     // [RL5]
    end else begin
      if (sck_rise) begin
        spi_shift <= {spi_shift[5:0], s_si};       // [RL6] [RL9]
        // Past sixteen bits the next byte continues at the next address
        spi_cnt   <= (spi_cnt == `SHP_SPI_CYCLE_BITS) ? `SHP_SPI_WRAP : 5'(spi_cnt + 5'h01); // [RL10]
      end
      if (spi_hdr_done) begin
        spi_addr  <= {1'b0, spi_shift};            // [RL3]
        spi_write <= s_si;                         // [RL4]
      end
      if (spi_byte_done) begin
        spi_addr <= 8'(spi_addr + 8'h01);          // [RL22]
      end
      if (spi_launch) begin
        serial_out_oe_o <= 1'b1;                   // [RL5]
        serial_out_o    <= out_shift[7];           // [RL6] [RL9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave

  serial_port_pkg::i2c_state_t i2c_state;
  logic [3:0] i2c_cnt;
  logic [6:0] i2c_shift;
  logic [7:0] i2c_ptr;
  logic       ack_pending;

  logic       i2c_start;
  logic       i2c_stop;
  logic       i2c_rise;
  logic       i2c_byte;
  logic       i2c_ninth;
  logic       in_read;
  logic       host_acks;
  logic [7:0] byte_val;
  logic [6:0] own_id;
  logic       id_match;
  logic       i2c_wr_evt;
  logic       i2c_rd_evt;
  logic       i2c_launch;
  logic [7:0] i2c_rd_addr;

  // Conditions seen while the clock stays high
  assign i2c_start   = i2c_mode & s_sck & sck_prev & sda_prev & ~s_sda;   // [RL13]
  assign i2c_stop    = i2c_mode & s_sck & sck_prev & ~sda_prev & s_sda;   // [RL14]
  assign i2c_rise    = i2c_mode & sck_rise & (i2c_state != serial_port_pkg::I2C_IDLE);
  assign i2c_byte    = i2c_rise & (i2c_cnt == `SHP_I2C_BYTE_LAST);
  assign i2c_ninth   = i2c_rise & (i2c_cnt == `SHP_I2C_ACK_BIT);
  assign in_read     = (i2c_state == serial_port_pkg::I2C_READ);
  // Ninth bit after a byte we sent; our own address ack must not count as the host's
  assign host_acks   = in_read & ~ack_pending;                            // [RL20]
  assign byte_val    = {i2c_shift, s_sda};                                // [RL20]
  assign own_id      = s_si ? `SHP_I2C_ID_A0_HIGH : `SHP_I2C_ID_A0_LOW;  // [RL18]
  assign id_match    = (byte_val[7:1] == own_id);                         // [RL18]
  assign i2c_wr_evt  = i2c_byte & (i2c_state == serial_port_pkg::I2C_WRITE); // [RL19]
  assign i2c_rd_evt  = (i2c_byte & (i2c_state == serial_port_pkg::I2C_DEVADDR) & id_match & byte_val[0])
                     | (i2c_ninth & host_acks & ~s_sda);                  // [RL21]
  assign i2c_rd_addr = in_read ? 8'(i2c_ptr + 8'h01) : i2c_ptr;           // [RL22]
  assign i2c_launch  = i2c_mode & sck_fall & ~i2c_start & ~i2c_stop & in_read
                     & (i2c_cnt != `SHP_I2C_ACK_BIT);                     // [RL12]

  // Device only releases or pulls low; it never makes START or STOP
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i2c_state   <= serial_port_pkg::I2C_IDLE;
      i2c_cnt     <= 4'h0;
      i2c_shift   <= 7'h00;
      i2c_ptr     <= `SHP_ADDR_RESET;
      ack_pending <= 1'b0;
      sda_oe_o    <= 1'b0;
      sda_o       <= 1'b0;
      bus_busy_o  <= 1'b0;
    end else begin
      sda_o <= 1'b0;                                   // [RL11] [RL15]
      if (!i2c_mode) begin
        i2c_state   <= serial_port_pkg::I2C_IDLE;
        ack_pending <= 1'b0;
        sda_oe_o    <= 1'b0;
        bus_busy_o  <= 1'b0;
      end else if (i2c_start) begin
        i2c_state   <= serial_port_pkg::I2C_DEVADDR;   // [RL17]
        i2c_cnt     <= 4'h0;
        ack_pending <= 1'b0;
        sda_oe_o    <= 1'b0;
        bus_busy_o  <= 1'b1;                           // [RL16]
      end else if (i2c_stop) begin
        i2c_state   <= serial_port_pkg::I2C_IDLE;
        i2c_cnt     <= 4'h0;
        ack_pending <= 1'b0;
        sda_oe_o    <= 1'b0;
        bus_busy_o  <= 1'b0;                           // [RL16]
      end else begin
        if (i2c_ninth) begin
          i2c_cnt     <= 4'h0;
          ack_pending <= 1'b0;
          if (host_acks && s_sda) begin
            i2c_state <= serial_port_pkg::I2C_IDLE;    // Master refused, wait for STOP
          end else if (host_acks) begin
            i2c_ptr <= 8'(i2c_ptr + 8'h01);            // [RL22]
          end
        end else if (i2c_rise) begin
          i2c_shift <= byte_val[6:0];                  // [RL20]
          i2c_cnt   <= 4'(i2c_cnt + 4'h1);
          if (i2c_byte) begin
            unique case (i2c_state)
              serial_port_pkg::I2C_DEVADDR: begin
                ack_pending <= id_match;               // [RL18] [RL20]
                if (!id_match) begin
                  i2c_state <= serial_port_pkg::I2C_IDLE;
                end else if (byte_val[0]) begin
                  i2c_state <= serial_port_pkg::I2C_READ;
                end else begin
                  i2c_state <= serial_port_pkg::I2C_REGADDR;
                end
              end
              serial_port_pkg::I2C_REGADDR: begin
                i2c_ptr     <= byte_val;               // [RL19]
                ack_pending <= 1'b1;
                i2c_state   <= serial_port_pkg::I2C_WRITE;
              end
              serial_port_pkg::I2C_WRITE: begin
                i2c_ptr     <= 8'(i2c_ptr + 8'h01);    // [RL22]
                ack_pending <= 1'b1;                   // [RL20]
              end
              serial_port_pkg::I2C_READ: begin
                ack_pending <= 1'b0;                   // Master acknowledges reads
              end
              serial_port_pkg::I2C_IDLE: begin
                ack_pending <= 1'b0;
              end
            endcase
          end
        end
        // Drive changes only on the falling clock
        if (i2c_mode && sck_fall) begin
          if (i2c_cnt == `SHP_I2C_ACK_BIT) begin
            sda_oe_o <= ack_pending;                   // [RL20] [RL12]
          end else if (in_read) begin
            sda_oe_o <= ~out_shift[7];                 // [RL11] [RL12]
          end else begin
            sda_oe_o <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file requests and read data shifter

  serial_port_pkg::reg_req_t next_req;
  logic                      load_pending;

  // Only one mode is live, so the two request sources never collide
  assign next_req.wr    = spi_wr_evt | i2c_wr_evt;
  assign next_req.rd    = spi_rd_evt | i2c_rd_evt;
  assign next_req.addr  = spi_mode ? (spi_wr_evt ? spi_addr : spi_rd_addr)
                                   : (i2c_wr_evt ? i2c_ptr : i2c_rd_addr);
  assign next_req.wdata = spi_mode ? {spi_shift, s_si} : byte_val;

  // Read data is taken two cycles after the read strobe, well before the next falling edge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_req_o    <= '0;
      load_pending <= 1'b0;
      out_shift    <= `SHP_DATA_RESET;
    end else begin
      reg_req_o    <= next_req;
      load_pending <= reg_req_o.rd;
      if (load_pending) begin
        out_shift <= reg_rdata_i;
      end else if (spi_launch || i2c_launch) begin
        out_shift <= {out_shift[6:0], 1'b0};           // [RL6] [RL20]
      end
    end
  end

endmodule

// >>> logic/serial_port_params.svh
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Serial control mode strap level that selects the two-wire mode
`define SHP_INTERFACE_SELECT_PIN_I2C_LEVEL  1'h0

// Four-wire cycle: bit counts
`define SHP_SPI_HDR_LAST     5'h07
`define SHP_SPI_BYTE_LAST    5'h0f
`define SHP_SPI_CYCLE_BITS   5'h10
`define SHP_SPI_WRAP         5'h09
`define SHP_SPI_DATA_FIRST   5'h08

// Two-wire bus: bit counts and chip identifiers
`define SHP_I2C_BYTE_LAST    4'h7
`define SHP_I2C_ACK_BIT      4'h8
`define SHP_I2C_ID_A0_LOW    7'h20
`define SHP_I2C_ID_A0_HIGH   7'h21

// Reset values
`define SHP_ADDR_RESET       8'h00
`define SHP_DATA_RESET       8'h00
`define SHP_PIN_IDLE         5'h1f

`endif

// >>> logic/serial_port_pkg.sv
package serial_port_pkg;

  // Request towards the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Two-wire receive sequence
  typedef enum logic [4:0] {
    I2C_IDLE    = 5'b0_0001,
    I2C_DEVADDR = 5'b0_0010,
    I2C_REGADDR = 5'b0_0100,
    I2C_WRITE   = 5'b0_1000,
    I2C_READ    = 5'b1_0000
  } i2c_state_t;

endpackage

// >>> verification/host_model.sv
`timescale 1ns/1ns

// Host controller: four-wire master with a 64 ns link period, two-wire master with 72 ns per bit
module host_model (
  input  wire logic clock_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  input  wire logic sda_i,
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      si_o,
  output logic      sda_pull_o
);
  // Idle: deselected, two-wire lines released
  initial begin
    sck_o = 1'h1;
    ss_n_o = 1'h1;
    si_o = 1'h0;
    sda_pull_o = 1'h0;
  end
  // Half a link period, moving only on falling system clock edges
  task automatic h();
    repeat (4) @(negedge clock_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // One framed transfer of n bits; the last 8 read back bits are kept
  task automatic spi(input logic [23:0] w, input int n, output logic [7:0] rx);
    @(negedge clock_i);
    sck_o = 1'h0;
    ss_n_o = 1'h0;  // Held low through the whole cycle
    for (int i = 0; i < n; i++) begin
      si_o = w[23-i];  // Address, flag, data, MSB first
      h();
      sck_o = 1'h1;  // Device samples on this rise
      h();
      rx = {rx[6:0], so_oe_i ? so_i : 1'hx};  // Late in the high phase, so latency is covered
      sck_o = 1'h0;
    end
    h();
    ss_n_o = 1'h1;  // High between cycles
    si_o = ~si_o;  // Released line must not show the last bit
    h();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // One two-wire bit; data moves a cycle after the fall, never with clock high
  task automatic bit9(input logic d, output logic q);
    @(negedge clock_i);
    sda_pull_o = ~d;
    h();
    sck_o = 1'h1;
    h();
    q = sda_i;
    sck_o = 1'h0;
  endtask
  // Byte plus ninth bit; m9 low acknowledges a byte the device sent
  task automatic i2c_byte(input logic [7:0] tx, input logic m9, output logic [7:0] rx, output logic a9);
    for (int i = 7; i >= 0; i--) bit9(tx[i], rx[i]);  // MSB first
    bit9(m9, a9);
  endtask
  // Only the host makes start and stop; a start may repeat inside a transfer
  task automatic i2c_start();
    @(negedge clock_i);
    sda_pull_o = 1'h0;
    h();
    sck_o = 1'h1;
    h();
    sda_pull_o = 1'h1;
    h();
    sck_o = 1'h0;
  endtask
  task automatic i2c_stop();
    @(negedge clock_i);
    sda_pull_o = 1'h1;
    h();
    sck_o = 1'h1;
    h();
    sda_pull_o = 1'h0;
    h();
  endtask
endmodule

// >>> verification/serial_host_port_chk.sv
`timescale 1ns/1ns

// Pin-level checks on the serial host port
module serial_host_port_chk (
  input wire logic                 clock_i,
  input wire logic                 resetn_i,
  input wire logic                 interface_select_pin_i,
  input wire logic                 slave_select_n_i,
  input wire logic                 serial_clock_i,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe_o,
  input wire logic                 serial_out_oe_o,
  input wire logic                 bus_busy_o,
  input serial_port_pkg::reg_req_t reg_req_o
);
  // How long select has been high and each mode has held; saturates so it never wraps
  logic [3:0] ss_cnt;
  logic [3:0] i2c_cnt;
  logic [3:0] spi_cnt;
  function automatic logic [3:0] sat(input logic [3:0] c, input logic go);
    return go ? c + {3'h0, c != 4'hf} : 4'h0;
  endfunction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ss_cnt <= 4'h0;
      i2c_cnt <= 4'h0;
      spi_cnt <= 4'h0;
    end else begin
      ss_cnt <= sat(ss_cnt, slave_select_n_i);
      i2c_cnt <= sat(i2c_cnt, !interface_select_pin_i);
      spi_cnt <= sat(spi_cnt, interface_select_pin_i);
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////////////
  // Data edges with the clock high on both sides; counts keep mode switches out
  sequence s_start;
    i2c_cnt >= 4'h8 && serial_clock_i && $past(serial_clock_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    i2c_cnt >= 4'h8 && serial_clock_i && $past(serial_clock_i) && $rose(sda_i);
  endsequence
  a_drain_only: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_so_quiet_i2c: assert property (i2c_cnt >= 4'h8 |-> !serial_out_oe_o)
    else $error("serial out driven in two-wire mode");
  a_sda_quiet_spi: assert property (spi_cnt >= 4'h8 |-> !sda_oe_o && !bus_busy_o)
    else $error("two-wire side active in four-wire mode");
  a_select_resets: assert property (spi_cnt >= 4'h8 && ss_cnt >= 4'h8
    |-> !serial_out_oe_o && !reg_req_o.wr && !reg_req_o.rd)
    else $error("activity while deselected");
  a_so_needs_select: assert property ($rose(serial_out_oe_o) |-> !slave_select_n_i)
    else $error("serial out enabled without select");
  a_req_one_kind: assert property (!(reg_req_o.wr && reg_req_o.rd))
    else $error("read and write together");
  a_wr_one_pulse: assert property (reg_req_o.wr |=> !reg_req_o.wr)
    else $error("write request longer than a cycle");
  a_start_busy: assert property (s_start |-> ##[1:6] bus_busy_o)
    else $error("start not seen as busy");
  a_stop_free: assert property (s_stop |-> ##[1:6] !bus_busy_o)
    else $error("stop not seen as free");
  a_sda_on_low: assert property (i2c_cnt >= 4'h8 && $rose(sda_oe_o) |-> !serial_clock_i)
    else $error("data pulled while clock high");
endmodule

bind serial_host_port serial_host_port_chk chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .interface_select_pin_i(interface_select_pin_i),
  .slave_select_n_i(slave_select_n_i), .serial_clock_i(serial_clock_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .serial_out_oe_o(serial_out_oe_o),
  .bus_busy_o(bus_busy_o), .reg_req_o(reg_req_o)
);

// >>> verification/tb.sv
`timescale 1ns/1ns

module tb;
  logic                      clock_i = 1'h0;
  logic                      resetn_i = 1'h0;
  logic                      strap = 1'h1;
  logic [7:0]                rdata = 8'h00;
  logic                      sck, ss_n, si, pull, sda_line, sda_o, sda_oe, so, so_oe, busy;
  serial_port_pkg::reg_req_t req;
  logic [16:0]               evq[$];
  int                        err_total = 0;
  int                        n_checks = 0;

  always #4 clock_i = ~clock_i;
  // Pulled up unless either party sinks it
  assign sda_line = ~(pull | (sda_oe & ~sda_o));

  host_model host (.clock_i(clock_i), .so_i(so), .so_oe_i(so_oe), .sda_i(sda_line),
    .sck_o(sck), .ss_n_o(ss_n), .si_o(si), .sda_pull_o(pull));
  serial_host_port uut (.clock_i(clock_i), .resetn_i(resetn_i), .interface_select_pin_i(strap),
    .slave_select_n_i(ss_n), .serial_clock_i(sck), .serial_in_addr_bit_pin_i(si), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .serial_out_o(so), .serial_out_oe_o(so_oe),
    .bus_busy_o(busy), .reg_req_o(req), .reg_rdata_i(rdata));

  //////////////////////////////////////////////////////////////////////////////
  // Register file stand-in: read data ready half a cycle after the request, on the falling clock
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'h5a;
  endfunction
  always @(negedge clock_i) begin
    if (req.rd === 1'h1) rdata <= rd_val(req.addr);
  end
  // Log of every request, in order; sampled mid-cycle, clear of the launching edge
  always @(negedge clock_i) begin
    if (req.wr === 1'h1) evq.push_back({1'h1, req.addr, req.wdata});
    if (req.rd === 1'h1) evq.push_back({1'h0, req.addr, 8'h00});
  end

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Next logged request, waited for under a bound
  task automatic take(input string what, input logic [16:0] exp);
    for (int i = 0; i < 40 && evq.size() == 0; i++) @(posedge clock_i);
    if (evq.size() == 0) begin
      err_total++;
      $display("[ERR] %s expected %h seen none", what, exp);
      finish_test();
    end
    chk(what, exp, evq.pop_front());
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic spi_write();
    logic [7:0] rx;
    host.spi({7'h05, 1'h1, 8'ha5, 8'h00}, 16, rx);
    take("spi write", {1'h1, 8'h05, 8'ha5});
    $display("spi_write done");
  endtask
  task automatic spi_read();
    logic [7:0] rx;
    host.spi({7'h2a, 1'h0, 8'hff, 8'h00}, 16, rx);
    take("spi read req", {1'h0, 8'h2a, 8'h00});
    take("spi prefetch", {1'h0, 8'h2b, 8'h00});
    chk("spi read data", {9'h000, rd_val(8'h2a)}, {9'h000, rx});
    chk("so released", 17'h0_0000, {16'h0000, so_oe});
    $display("spi_read done");
  endtask
  task automatic spi_burst();
    logic [7:0] rx;
    host.spi({7'h11, 1'h1, 8'h33, 8'h44}, 24, rx);
    take("burst first", {1'h1, 8'h11, 8'h33});
    take("burst second", {1'h1, 8'h12, 8'h44});
    $display("spi_burst done");
  endtask
  task automatic spi_abort();
    logic [7:0] rx;
    host.spi({7'h33, 1'h1, 8'hff, 8'h00}, 10, rx);
    host.spi({7'h06, 1'h1, 8'h3c, 8'h00}, 16, rx);
    take("after abort", {1'h1, 8'h06, 8'h3c});
    chk("extra req", 17'h0_0000, 17'(evq.size()));
    $display("spi_abort done");
  endtask
  task automatic i2c_write();
    logic [7:0] rx;
    logic       a;
    @(negedge clock_i);
    strap = 1'h0;
    host.sck_o = 1'h1;
    host.si_o = 1'h0;
    repeat (8) @(negedge clock_i);
    host.i2c_start();
    host.i2c_byte(8'h40, 1'h1, rx, a);
    chk("id 20h ack", 17'h0_0000, {16'h0000, a});
    chk("busy", 17'h0_0001, {16'h0000, busy});
    host.i2c_byte(8'h10, 1'h1, rx, a);
    chk("reg ack", 17'h0_0000, {16'h0000, a});
    host.i2c_byte(8'h5a, 1'h1, rx, a);
    host.i2c_stop();
    repeat (4) @(negedge clock_i);
    chk("free", 17'h0_0000, {16'h0000, busy});
    take("i2c write", {1'h1, 8'h10, 8'h5a});
    $display("i2c_write done");
  endtask
  task automatic i2c_read();
    logic [7:0] rx;
    logic       a;
    @(negedge clock_i);
    host.si_o = 1'h1;
    host.i2c_start();
    host.i2c_byte(8'h40, 1'h1, rx, a);
    chk("id 20h refused", 17'h0_0001, {16'h0000, a});
    host.i2c_start();
    host.i2c_byte(8'h42, 1'h1, rx, a);
    chk("id 21h ack", 17'h0_0000, {16'h0000, a});
    host.i2c_byte(8'h20, 1'h1, rx, a);
    host.i2c_start();
    host.i2c_byte(8'h43, 1'h1, rx, a);
    chk("read id ack", 17'h0_0000, {16'h0000, a});
    host.i2c_byte(8'hff, 1'h0, rx, a);
    chk("i2c data 20", {9'h000, rd_val(8'h20)}, {9'h000, rx});
    host.i2c_byte(8'hff, 1'h1, rx, a);
    chk("i2c data 21", {9'h000, rd_val(8'h21)}, {9'h000, rx});
    host.i2c_stop();
    take("i2c rd 20", {1'h0, 8'h20, 8'h00});
    take("i2c rd 21", {1'h0, 8'h21, 8'h00});
    chk("extra req", 17'h0_0000, 17'(evq.size()));
    $display("i2c_read done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clock_i);
    resetn_i = 1'h1;
    repeat (6) @(negedge clock_i);
    spi_write();
    spi_read();
    spi_burst();
    spi_abort();
    i2c_write();
    i2c_read();
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge clock_i);
    err_total++;
    $display("[ERR] run length expected under 50000 cycles seen more");
    finish_test();
  end
endmodule
